// [dv/apk_net_elem.sv]
// Network element model: makes the frame marker, answers K bytes, captures the sent ones.
// Assumes the block's K slot starts the cycle after frameSync, one bit per clock.
`timescale 1ns/1ps
module apk_net_elem (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] rxWord,
    input wire logic txBit,
    input wire logic txBitValid,
    output logic frameSync,
    output logic rxBit,
    output logic [15:0] capWord
);
    logic [4:0] cnt;
    logic [15:0] shReg;
    logic lastValid;
    // ==========================================
    // Framing, answer and capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 5'h0;
            frameSync <= 1'b0;
            rxBit <= 1'b0;
            shReg <= 16'h0;
            lastValid <= 1'b0;
            capWord <= 16'h0;
        end else begin
            cnt <= (cnt == 5'h13) ? 5'h0 : cnt + 5'h1;
            frameSync <= (cnt == 5'h13);
            if (cnt < 5'h10) begin
                rxBit <= rxWord[4'hF - cnt[3:0]];
            end else begin
                // Toggle outside the slot so a stale bit never looks valid
                rxBit <= ~rxBit;
            end
            lastValid <= txBitValid;
            if (txBitValid) begin
                shReg <= {shReg[14:0], txBit};
            end
            if (lastValid && !txBitValid) begin
                capWord <= shReg;
            end
        end
    end
endmodule : apk_net_elem

// [dv/test_aps_k2_field_and_transmit_staging.sv]
// Self-checking bench for the K1/K2 staging block, APB master and network element model.
// Assumes zero or more APB wait states and a 20-cycle frame from the model.
`timescale 1ns/1ps
module test_aps_k2_field_and_transmit_staging;
    import apk_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic lineAisActive, lineFerfActive, frameSync, rxBit, txBit, txBitValid;
    logic [15:0] rxWord, capWord;
    int nErrors, checkCount, cycles;
    integer seed;
    apk_stage_top #(.ADDR_W(8)) i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lineAisActive(lineAisActive), .lineFerfActive(lineFerfActive),
        .frameSync(frameSync), .rxBit(rxBit), .txBit(txBit), .txBitValid(txBitValid));
    apk_net_elem i_net (.clock(clock), .rst(rst), .rxWord(rxWord), .txBit(txBit),
        .txBitValid(txBitValid), .frameSync(frameSync), .rxBit(rxBit), .capWord(capWord));
    // ==========================================
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            $display("Error timeout expected finish seen hang");
            printVerdict();
        end
    end
    // ==========================================
    // Checks and bus cycles
    task automatic printVerdict();
        $display("Checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : printVerdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
        check(what, exp & m, r & m);
    endtask : rd
    function automatic logic [31:0] statusWord(input logic [2:0] c, input logic md, input logic rf, input logic al);
        return {25'h0, c, md, (c >= 3'h3 && c <= 3'h5), rf, al};
    endfunction : statusWord
    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] rnd, r;
        logic [15:0] stg, expTx;
        logic e;
        seed = 32'hE4EE;
        {psel, penable, pwrite, paddr, pwdata, lineAisActive, lineFerfActive, rxWord} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        stg = 16'hAAAA;
        expTx = 16'h0;
        rd("stage", APK_STAGE_OFS, {16'h0, stg}, 32'hFFFFFFFF);
        rd("txk", APK_TXK_OFS, 32'h0, 32'hFFFFFFFF);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            stg = rnd[15:0];
            wr(APK_STAGE_OFS, {16'h0, stg});
            rd("txk", APK_TXK_OFS, {16'h0, expTx}, 32'hFFFFFFFF);
            wr(APK_CMD_OFS, 32'h7);
            expTx = stg;
            rd("txk", APK_TXK_OFS, {16'h0, expTx}, 32'hFFFFFFFF);
            wr(APK_CMD_OFS, 32'h2);
            rd("txk", APK_TXK_OFS, 32'h0, 32'hFFFFFFFF);
            wr(APK_CMD_OFS, 32'h4);
            expTx = 16'hFFFF;
            rd("txk", APK_TXK_OFS, {16'h0, expTx}, 32'hFFFFFFFF);
            rnd = $random(seed);
            expTx = rnd[15:0];
            wr(APK_TXK_OFS, rnd);
            rd("txk", APK_TXK_OFS, {16'h0, expTx}, 32'hFFFFFFFF);
        end
        $display("Test commands done");
        for (int md = 0; md < 2; md++) begin
            wr(APK_CTRL_OFS, md);
            for (int c = 0; c < 8; c++) begin
                rnd = $random(seed);
                wr(APK_FIELD_OFS, {20'h0, 4'h1, rnd[7:4], 4'h0});
                wr(APK_FIELD_OFS, {20'h0, 4'h2, 4'h0, rnd[3], 3'h0});
                wr(APK_FIELD_OFS, {20'h0, 4'h4, 5'h0, c[2:0]});
                stg[7:0] = {rnd[7:3], c[2:0]};
                rd("field", APK_FIELD_OFS, {24'h0, stg[7:0]}, 32'h000000FF);
                wr(APK_CMD_OFS, 32'h1);
                expTx = stg;
                rd("status", APK_STATUS_OFS, statusWord(c[2:0], md[0], 1'b0, 1'b0), 32'hFFFFFFFF);
            end
        end
        $display("Test fields done");
        wr(APK_PRESET_OFS, 32'h2);
        rd("preset", APK_FIELD_OFS, 32'hFF, 32'hFF);
        wr(APK_PRESET_OFS, 32'h4);
        rd("preset", APK_FIELD_OFS, 32'hAA, 32'hFF);
        wr(APK_PRESET_OFS, 32'h3);
        rd("preset", APK_FIELD_OFS, 32'h00, 32'hFF);
        stg[7:0] = APK_K_ZERO;
        $display("Test presets done");
        for (int j = 0; j < 2; j++) begin
            lineAisActive <= (j == 0);
            lineFerfActive <= (j == 1);
            wr(APK_CMD_OFS, 32'h2);
            wr(APK_TXK_OFS, 32'h1234);
            rd("txk", APK_TXK_OFS, {16'h0, expTx}, 32'hFFFFFFFF);
            rd("status", APK_STATUS_OFS, 32'h3, 32'h3);
            lineAisActive <= 1'b0;
            lineFerfActive <= 1'b0;
            wr(APK_STATUS_OFS, 32'h2);
            rd("status", APK_STATUS_OFS, 32'h0, 32'h3);
        end
        $display("Test alarm done");
        for (int k = 0; k < 3; k++) begin
            rnd = $random(seed);
            rxWord <= rnd[31:16];
            expTx = rnd[15:0];
            wr(APK_TXK_OFS, rnd);
            repeat (45) @(posedge clock);
            check("captured tx", {16'h0, expTx}, {16'h0, capWord});
            rd("rxk", APK_RXK_OFS, {16'h0, rnd[31:16]}, 32'hFFFFFFFF);
        end
        $display("Test link done");
        xfer(1'b0, 8'h20, 32'h0, r, e);
        check("pslverr", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, r);
        xfer(1'b1, 8'h06, 32'hFFFF, r, e);
        check("pslverr", 32'h1, {31'h0, e});
        rd("stage", APK_STAGE_OFS, {16'h0, stg}, 32'hFFFF);
        $display("Test unmapped done");
        printVerdict();
    end
endmodule : test_aps_k2_field_and_transmit_staging

// [logic/apk_link.sv]
// Inserts the transmitted K bytes into each frame's slot and captures the received ones.
// Assumes frameSync marks the cycle before the 16-bit K1/K2 slot, one bit per clock.
`timescale 1ns/1ps
module apk_link
    import apk_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic frameSync,
    input wire logic rxBit,
    output logic txBit,
    output logic txBitValid,
    apk_link_if.link lnk
);
    import apk_pkg::*;

    typedef struct packed {
        logic [15:0] txSh;
        logic [4:0] txCnt;
        logic [15:0] rxSh;
        logic [4:0] rxCnt;
        logic [7:0] rxK1;
        logic [7:0] rxK2;
        logic rxValid;
    } apk_link_s;

    apk_link_s st_q, st_d;

    // ========================================
    // Slot sequencing
    always_comb begin
        st_d = st_q;
        st_d.rxValid = 1'b0;
        if (st_q.txCnt != 5'h00) begin
            st_d.txSh = {st_q.txSh[14:0], 1'b0};
            st_d.txCnt = st_q.txCnt - 5'h01;
        end
        if (st_q.rxCnt != 5'h00) begin
            st_d.rxSh = {st_q.rxSh[14:0], rxBit};
            st_d.rxCnt = st_q.rxCnt - 5'h01;
            if (st_q.rxCnt == 5'h01) begin
                {st_d.rxK1, st_d.rxK2} = {st_q.rxSh[14:0], rxBit};
                st_d.rxValid = 1'b1;
            end
        end
        if (frameSync) begin
            st_d.txSh = {lnk.txK1, lnk.txK2};
            st_d.txCnt = APK_SLOT_BITS;
            st_d.rxCnt = APK_SLOT_BITS;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign txBit = st_q.txSh[15];
    assign txBitValid = (st_q.txCnt != 5'h00);
    assign lnk.rxK1 = st_q.rxK1;
    assign lnk.rxK2 = st_q.rxK2;
    assign lnk.rxValid = st_q.rxValid;

    property p_tx_first_bit;
        @(posedge clock) disable iff (rst)
        frameSync |=> txBitValid && (txBit == $past(lnk.txK1[7]));
    endproperty
    a_tx_first_bit: assert property (p_tx_first_bit) else $error("K1 bit one not sent first");

    property p_tx_slot_len;
        @(posedge clock) disable iff (rst)
        frameSync ##1 !frameSync [*8] |-> txBitValid;
    endproperty
    a_tx_slot_len: assert property (p_tx_slot_len) else $error("K slot ended early");
endmodule : apk_link

// [logic/apk_link_if.sv]
// Interface between the register side and the overhead serialiser.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface apk_link_if;
    logic [7:0] txK1;
    logic [7:0] txK2;
    logic [7:0] rxK1;
    logic [7:0] rxK2;
    logic rxValid;
    modport ctrl (output txK1, output txK2, input rxK1, input rxK2, input rxValid);
    modport link (input txK1, input txK2, output rxK1, output rxK2, output rxValid);
endinterface : apk_link_if

// [logic/apk_pkg.sv]
// Package for the K1/K2 protection byte staging block.
// Assumes a 32-bit APB register bus and one 20 MHz clock.
package apk_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] APK_CTRL_OFS = 8'h00;
    localparam logic [7:0] APK_STAGE_OFS = 8'h04;
    localparam logic [7:0] APK_FIELD_OFS = 8'h08;
    localparam logic [7:0] APK_PRESET_OFS = 8'h0C;
    localparam logic [7:0] APK_CMD_OFS = 8'h10;
    localparam logic [7:0] APK_TXK_OFS = 8'h14;
    localparam logic [7:0] APK_RXK_OFS = 8'h18;
    localparam logic [7:0] APK_STATUS_OFS = 8'h1C;
    // Field positions; K bit one is the most significant bit
    localparam int APK_CHAN_LSB = 4;
    localparam int APK_ARCH_BIT = 3;
    localparam int APK_STAT_LSB = 0;
    localparam int APK_FSEL_CHAN = 8;
    localparam int APK_FSEL_ARCH = 9;
    localparam int APK_FSEL_STAT = 10;
    localparam int APK_CMD_APPLY = 0;
    localparam int APK_CMD_DEFAULT = 1;
    localparam int APK_CMD_ILLEGAL = 2;
    localparam int APK_PRE_ZERO = 0;
    localparam int APK_PRE_ONE = 1;
    localparam int APK_PRE_DEF = 2;
    localparam int APK_ST_ALARM = 0;
    localparam int APK_ST_REFUSED = 1;
    localparam int APK_ST_UNUSED = 2;
    localparam int APK_ST_MODE = 3;
    // Reset and preset values
    localparam logic [7:0] APK_K_DEFAULT = 8'hAA;
    localparam logic [7:0] APK_K_ZERO = 8'h00;
    localparam logic [7:0] APK_K_ONE = 8'hFF;
    // Status codes of K2 bits six to eight
    localparam logic [2:0] APK_STAT_IDLE = 3'h0;
    localparam logic [2:0] APK_STAT_BRIDGED = 3'h1;
    localparam logic [2:0] APK_STAT_BRSW = 3'h2;
    localparam logic [2:0] APK_STAT_FERF = 3'h6;
    localparam logic [2:0] APK_STAT_AIS = 3'h7;
    // Bits in one K1+K2 slot
    localparam logic [4:0] APK_SLOT_BITS = 5'h10;
endpackage : apk_pkg

// [logic/apk_stage_top.sv]
// K1/K2 protection byte staging: APB registers, transmit commands, received capture.
// Assumes an APB master with 32-bit data and a frame slot marker from the line side.
// Operation
// - K1 carries request, K2 architecture/status
// - Ring or span mode setting held
// - Staged K2 by bit, field, presets
// - K2 bits one-four take any channel
// - Span bit five: architecture select
// - Ring bit five: short or long path
// - Bits six-eight carry status codes
// - Staging writes leave transmitted bytes alone
// - Apply copies staged into transmitted
// - Send-default makes transmitted all zeros
// - Send-illegal makes transmitted all ones
// - No transmit loads during line alarms
// - Readback shows newly transmitted bytes
// - Transmitted bytes writable directly
// - Received K bytes captured for readback
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module apk_stage_top
    import apk_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lineAisActive,
    input wire logic lineFerfActive,
    input wire logic frameSync,
    input wire logic rxBit,
    output logic txBit,
    output logic txBitValid
);
    import apk_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic ringMode;
        logic [7:0] stK1;
        logic [7:0] stK2;
        logic [7:0] txK1;
        logic [7:0] txK2;
        logic [7:0] rxK1;
        logic [7:0] rxK2;
        logic refused;
        logic [31:0] rdData;
    } apk_state_s;

    apk_state_s st_q, st_d;
    apk_link_if lnk ();

    logic wrEn;
    logic rdEn;
    logic rdSetup;
    logic [31:0] rdMux;
    logic hit;
    logic alarmTx;
    logic [7:0] ofs;

    function automatic logic apk_unused_stat(input logic [2:0] code);
        return (code > APK_STAT_BRSW) && (code < APK_STAT_FERF);
    endfunction : apk_unused_stat

    // Merge selected K2 fields from a field write
    function automatic logic [7:0] apk_merge(input logic [7:0] k, input logic [31:0] w);
        logic [7:0] r;
        r = k;
        if (w[APK_FSEL_CHAN]) begin
            r[APK_CHAN_LSB +: 4] = w[APK_CHAN_LSB +: 4];
        end
        if (w[APK_FSEL_ARCH]) begin
            r[APK_ARCH_BIT] = w[APK_ARCH_BIT];
        end
        if (w[APK_FSEL_STAT]) begin
            r[APK_STAT_LSB +: 3] = w[APK_STAT_LSB +: 3];
        end
        return r;
    endfunction : apk_merge

    // ========================================
    // APB decode; zero wait states
    assign ofs = paddr[7:0];
    assign wrEn = psel && penable && pwrite && hit;
    assign rdEn = psel && penable && !pwrite && hit;
    assign rdSetup = psel && !penable && !pwrite && hit;
    assign pready = 1'b1;
    assign alarmTx = lineAisActive || lineFerfActive;

    always_comb begin
        case (ofs)
            APK_CTRL_OFS, APK_STAGE_OFS, APK_FIELD_OFS, APK_PRESET_OFS,
            APK_CMD_OFS, APK_TXK_OFS, APK_RXK_OFS, APK_STATUS_OFS: hit = ((paddr >> 8) == '0);
            default: hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !hit;

    // ========================================
    // State update
    always_comb begin
        st_d = st_q;
        // Sampled at setup so read data comes from a flop in the access phase
        st_d.rdData = rdSetup ? rdMux : 32'h0000_0000;
        if (wrEn && hit) begin
            case (ofs)
                APK_CTRL_OFS: st_d.ringMode = pwdata[0];
                APK_STAGE_OFS: {st_d.stK1, st_d.stK2} = pwdata[15:0];
                APK_FIELD_OFS: st_d.stK2 = apk_merge(st_q.stK2, pwdata);
                APK_PRESET_OFS: begin
                    if (pwdata[APK_PRE_ZERO]) begin
                        st_d.stK2 = APK_K_ZERO;
                    end else if (pwdata[APK_PRE_ONE]) begin
                        st_d.stK2 = APK_K_ONE;
                    end else if (pwdata[APK_PRE_DEF]) begin
                        st_d.stK2 = APK_K_DEFAULT;
                    end
                end
                APK_CMD_OFS: begin
                    if (alarmTx) begin
                        st_d.refused = st_q.refused | (|pwdata[2:0]);
                    end else if (pwdata[APK_CMD_APPLY]) begin
                        st_d.txK1 = st_q.stK1;
                        st_d.txK2 = st_q.stK2;
                    end else if (pwdata[APK_CMD_DEFAULT]) begin
                        st_d.txK1 = APK_K_ZERO;
                        st_d.txK2 = APK_K_ZERO;
                    end else if (pwdata[APK_CMD_ILLEGAL]) begin
                        st_d.txK1 = APK_K_ONE;
                        st_d.txK2 = APK_K_ONE;
                    end
                end
                APK_TXK_OFS: begin
                    if (alarmTx) begin
                        st_d.refused = 1'b1;
                    end else begin
                        {st_d.txK1, st_d.txK2} = pwdata[15:0];
                    end
                end
                APK_STATUS_OFS: begin
                    // Writing one to the refused bit clears it; no set can fall in the same cycle
                    if (pwdata[APK_ST_REFUSED]) begin
                        st_d.refused = 1'b0;
                    end
                end
                default: st_d = st_d;
            endcase
        end
        if (lnk.rxValid) begin
            st_d.rxK1 = lnk.rxK1;
            st_d.rxK2 = lnk.rxK2;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '{ringMode: 1'b0, stK1: APK_K_DEFAULT, stK2: APK_K_DEFAULT,
                      txK1: APK_K_ZERO, txK2: APK_K_ZERO, rxK1: APK_K_ZERO,
                      rxK2: APK_K_ZERO, refused: 1'b0, rdData: 32'h0000_0000};
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================
    // Read mux
    always_comb begin
        rdMux = 32'h0000_0000;
        if (rdSetup) begin
            case (ofs)
                APK_CTRL_OFS: rdMux[0] = st_q.ringMode;
                APK_STAGE_OFS: rdMux[15:0] = {st_q.stK1, st_q.stK2};
                APK_FIELD_OFS: rdMux[7:0] = st_q.stK2;
                APK_TXK_OFS: rdMux[15:0] = {st_q.txK1, st_q.txK2};
                APK_RXK_OFS: rdMux[15:0] = {st_q.rxK1, st_q.rxK2};
                APK_STATUS_OFS: begin
                    rdMux[APK_ST_ALARM] = alarmTx;
                    rdMux[APK_ST_REFUSED] = st_q.refused;
                    rdMux[APK_ST_UNUSED] = apk_unused_stat(st_q.txK2[2:0]);
                    rdMux[APK_ST_MODE] = st_q.ringMode;
                    rdMux[7:4] = {1'b0, st_q.txK2[2:0]};
                end
                default: rdMux = 32'h0000_0000;
            endcase
        end
    end

    assign prdata = st_q.rdData;

    // ========================================
    // Overhead slot insertion
    // K1 then K2 in one slot
    assign lnk.txK1 = st_q.txK1;
    assign lnk.txK2 = st_q.txK2;

    apk_link u_link (
        .clock(clock),
        .rst(rst),
        .frameSync(frameSync),
        .rxBit(rxBit),
        .txBit(txBit),
        .txBitValid(txBitValid),
        .lnk(lnk)
    );

    // ========================================
    // Checks
    property p_stage_hold;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_STAGE_OFS) |=> (st_q.txK1 == $past(st_q.txK1)) && (st_q.txK2 == $past(st_q.txK2));
    endproperty
    a_stage_hold: assert property (p_stage_hold) else $error("Staging write moved transmitted bytes");

    property p_apply;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_CMD_OFS) && !alarmTx && pwdata[APK_CMD_APPLY]
            |=> {st_q.txK1, st_q.txK2} == $past({st_q.stK1, st_q.stK2});
    endproperty
    a_apply: assert property (p_apply) else $error("Apply did not copy staged bytes");

    property p_default;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_CMD_OFS) && !alarmTx && pwdata[2:0] == 3'h2 |=> {st_q.txK1, st_q.txK2} == 16'h0000;
    endproperty
    a_default: assert property (p_default) else $error("Send-default not all zeros");

    property p_illegal;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_CMD_OFS) && !alarmTx && pwdata[2:0] == 3'h4 |=> {st_q.txK1, st_q.txK2} == 16'hFFFF;
    endproperty
    a_illegal: assert property (p_illegal) else $error("Send-illegal not all ones");

    property p_alarm_lock;
        @(posedge clock) disable iff (rst)
        alarmTx && wrEn && ((ofs == APK_CMD_OFS && |pwdata[2:0]) || ofs == APK_TXK_OFS)
            |=> $stable({st_q.txK1, st_q.txK2}) && st_q.refused;
    endproperty
    a_alarm_lock: assert property (p_alarm_lock) else $error("Transmit load during line alarm");

    property p_readback;
        @(posedge clock) disable iff (rst)
        rdEn && (ofs == APK_TXK_OFS) |-> prdata[15:0] == {lnk.txK1, lnk.txK2};
    endproperty
    a_readback: assert property (p_readback) else $error("Transmitted readback mismatch");

    property p_direct;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_TXK_OFS) && !alarmTx |=> {st_q.txK1, st_q.txK2} == $past(pwdata[15:0]);
    endproperty
    a_direct: assert property (p_direct) else $error("Direct transmit write lost");

    property p_rx_capture;
        @(posedge clock) disable iff (rst)
        lnk.rxValid |=> {st_q.rxK1, st_q.rxK2} == $past({lnk.rxK1, lnk.rxK2});
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("Received bytes not captured");

    property p_preset_one;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_PRESET_OFS) && pwdata[2:0] == 3'h2 |=> st_q.stK2 == APK_K_ONE;
    endproperty
    a_preset_one: assert property (p_preset_one) else $error("All-ones preset failed");

    property p_mode;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_CTRL_OFS) |=> st_q.ringMode == $past(pwdata[0]);
    endproperty
    a_mode: assert property (p_mode) else $error("Mode write lost");

    property p_field_chan;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_FIELD_OFS) && pwdata[APK_FSEL_CHAN] |=> st_q.stK2[7:4] == $past(pwdata[7:4]);
    endproperty
    a_field_chan: assert property (p_field_chan) else $error("Channel field not staged");

    property p_field_arch;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_FIELD_OFS) && pwdata[APK_FSEL_ARCH] |=> st_q.stK2[3] == $past(pwdata[3]);
    endproperty
    a_field_arch: assert property (p_field_arch) else $error("Bit five not staged");

    property p_field_stat;
        @(posedge clock) disable iff (rst)
        wrEn && (ofs == APK_FIELD_OFS) && pwdata[APK_FSEL_STAT] |=> st_q.stK2[2:0] == $past(pwdata[2:0]);
    endproperty
    a_field_stat: assert property (p_field_stat) else $error("Status field not staged");
endmodule : apk_stage_top
